// file: hdl/ptz_resp_pkg.sv
// Constants and types for the camera response builder.
// Summary of operation
// - Pan/tilt reply data: 'P', three azimuth bytes, three elevation bytes.
// - Zoom/focus reply data: 'V', three zoom bytes, three focus bytes.
// - Latch reply data: 'L', high status byte, 'A', low status byte.
// - High status bits: manual iris, power on, fast lens, comm error.
// - Status bits 4,5 are one, bits 6,7 zero, low bit 3 zero.
// - Low status bits 0 to 2 show the three auxiliary outputs.
// - Preset reply: 'H' then the preset digit when parked at presets 0 to 9.
// - Preset status character is 'I' when idle and not at a preset.
// - Preset status character is 'A' while any goto motion runs.
// - Preset status character is 'E' when a goto target was unreachable.
// - Frame: header 0xF8, address, data bytes, checksum.
// - Checksum is 0x80 plus low nibble of XOR after header.
// - Positions split into three nibbles, MSB first, each plus 0x30.
// - Acknowledge 0x06 goes out first, then the response with no gap.
package ptz_resp_pkg;
   localparam logic [7:0] ACK_BYTE = 8'h06;
   localparam logic [7:0] HEADER_BYTE = 8'hf8;
   localparam logic [7:0] CHECKSUM_BASE = 8'h80;
   localparam logic [7:0] NIBBLE_BASE = 8'h30;
   localparam logic [7:0] STATUS_BASE = 8'h30;
   localparam logic [7:0] CHAR_PAN = 8'h50;
   localparam logic [7:0] CHAR_ZOOM = 8'h56;
   localparam logic [7:0] CHAR_LATCH = 8'h4c;
   localparam logic [7:0] CHAR_A = 8'h41;
   localparam logic [7:0] CHAR_PRESET = 8'h48;
   localparam logic [7:0] CHAR_IDLE = 8'h49;
   localparam logic [7:0] CHAR_ERROR = 8'h45;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [3:0] LEN_POSITION = 4'h7;
   localparam logic [3:0] LEN_LATCH = 4'h4;
   localparam logic [3:0] LEN_PRESET = 4'h2;
   typedef enum logic [1:0] {
      REQ_PAN_TILT,
      REQ_ZOOM_FOCUS,
      REQ_LATCH,
      REQ_PRESET
   } request_type;
   typedef enum {
      ST_IDLE,
      ST_ACK,
      ST_HEADER,
      ST_ADDRESS,
      ST_DATA,
      ST_CHECKSUM
   } phase_type;
endpackage

// file: hdl/ptz_camera_response_builder.sv
// Response builder: frames camera status replies into a two-entry output buffer.
`timescale 1ns/1ns
module ptz_camera_response_builder
   import ptz_resp_pkg::*;
#(
   parameter int POS_WIDTH = 12
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic req_valid,
   input wire request_type req_kind,
   output logic req_ready,
   input wire logic [7:0] remote_address,
   input wire logic [POS_WIDTH-1:0] azimuth_position,
   input wire logic [POS_WIDTH-1:0] elevation_position,
   input wire logic [POS_WIDTH-1:0] zoom_position,
   input wire logic [POS_WIDTH-1:0] focus_position,
   input wire logic iris_manual,
   input wire logic camera_power_on,
   input wire logic lens_speed_fast,
   input wire logic [2:0] aux_output_on,
   input wire logic bad_message,
   input wire logic goto_active,
   input wire logic goto_failed,
   input wire logic at_preset,
   input wire logic [3:0] preset_number,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_busy,
   output logic comm_error
);
   // The nibble slicing below serves exactly three nibbles per position.
   if (POS_WIDTH != 12) begin : g_width_check
      $error("Position encoding serves exactly three nibbles.");
   end

   typedef struct packed {
      phase_type phase;
      request_type kind;
      logic [3:0] index;
      logic [3:0] length;
      logic [7:0] cks;
      logic [7:0] addr;
      logic [7:0][7:0] data;
      logic comm_error;
      logic [1:0][7:0] buf_data;
      logic [1:0] count;
   } state_type;

   state_type r;
   state_type next_r;

   function automatic logic [7:0] enc_nibble(input logic [3:0] n);
      enc_nibble = NIBBLE_BASE | {4'h0, n};
   endfunction

   logic push;
   logic [7:0] push_byte;
   logic pop;
   logic [7:0] cur_byte;
   logic [7:0] status_high;
   logic [7:0] status_low;
   logic [7:0] preset_char;
   logic [7:0] tx_buf_out;

   assign req_ready = (r.phase == ST_IDLE);
   assign tx_busy = (r.phase != ST_IDLE);
   assign tx_valid = (r.count != 2'h0);
   assign tx_buf_out = r.buf_data[0];
   assign tx_data = tx_buf_out;
   assign comm_error = r.comm_error;
   assign pop = tx_valid && tx_ready;

   // Bits 4 and 5 set, 6 and 7 clear, come from the status base value.
   assign status_high = STATUS_BASE | {4'h0, r.comm_error, lens_speed_fast,
      camera_power_on, iris_manual};
   assign status_low = STATUS_BASE | {5'h00, aux_output_on};

   always_comb begin
      if (goto_active) begin
         preset_char = CHAR_A;
      end else if (goto_failed) begin
         preset_char = CHAR_ERROR;
      end else if (at_preset && preset_number <= 4'h9) begin
         preset_char = CHAR_ZERO + {4'h0, preset_number};
      end else begin
         preset_char = CHAR_IDLE;
      end
   end

   always_comb begin
      cur_byte = r.data[r.index[2:0]];
      push = 1'b0;
      push_byte = 8'h00;
      if (r.count != 2'h2) begin
         case (r.phase)
            ST_ACK: begin
               push = 1'b1;
               push_byte = ACK_BYTE;
            end
            ST_HEADER: begin
               push = 1'b1;
               push_byte = HEADER_BYTE;
            end
            ST_ADDRESS: begin
               push = 1'b1;
               push_byte = r.addr;
            end
            ST_DATA: begin
               push = 1'b1;
               push_byte = cur_byte;
            end
            ST_CHECKSUM: begin
               push = 1'b1;
               push_byte = CHECKSUM_BASE | {4'h0, r.cks[3:0]};
            end
            default: begin
               push = 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      next_r = r;
      // Set wins over clear: a fresh error while reporting stays pending.
      if (bad_message) begin
         next_r.comm_error = 1'b1;
      end
      case (r.phase)
         ST_IDLE: begin
            if (req_valid) begin
               // All fields captured in one cycle keep a reply consistent.
               next_r.kind = req_kind;
               next_r.addr = remote_address;
               next_r.index = 4'h0;
               next_r.cks = remote_address;
               next_r.data = '0;
               next_r.phase = ST_ACK;
               case (req_kind)
                  REQ_PAN_TILT: begin
                     next_r.length = LEN_POSITION;
                     next_r.data[0] = CHAR_PAN;
                     next_r.data[1] = enc_nibble(azimuth_position[11:8]);
                     next_r.data[2] = enc_nibble(azimuth_position[7:4]);
                     next_r.data[3] = enc_nibble(azimuth_position[3:0]);
                     next_r.data[4] = enc_nibble(elevation_position[11:8]);
                     next_r.data[5] = enc_nibble(elevation_position[7:4]);
                     next_r.data[6] = enc_nibble(elevation_position[3:0]);
                  end
                  REQ_ZOOM_FOCUS: begin
                     next_r.length = LEN_POSITION;
                     next_r.data[0] = CHAR_ZOOM;
                     next_r.data[1] = enc_nibble(zoom_position[11:8]);
                     next_r.data[2] = enc_nibble(zoom_position[7:4]);
                     next_r.data[3] = enc_nibble(zoom_position[3:0]);
                     next_r.data[4] = enc_nibble(focus_position[11:8]);
                     next_r.data[5] = enc_nibble(focus_position[7:4]);
                     next_r.data[6] = enc_nibble(focus_position[3:0]);
                  end
                  REQ_LATCH: begin
                     next_r.length = LEN_LATCH;
                     next_r.data[0] = CHAR_LATCH;
                     next_r.data[1] = status_high;
                     next_r.data[2] = CHAR_A;
                     next_r.data[3] = status_low;
                     // Reported now; only a new error in this cycle keeps it.
                     next_r.comm_error = bad_message;
                  end
                  default: begin
                     next_r.length = LEN_PRESET;
                     next_r.data[0] = CHAR_PRESET;
                     next_r.data[1] = preset_char;
                  end
               endcase
            end
         end
         ST_ACK: begin
            if (push) begin
               next_r.phase = ST_HEADER;
            end
         end
         ST_HEADER: begin
            if (push) begin
               next_r.phase = ST_ADDRESS;
            end
         end
         ST_ADDRESS: begin
            if (push) begin
               next_r.phase = ST_DATA;
            end
         end
         ST_DATA: begin
            if (push) begin
               next_r.cks = r.cks ^ cur_byte;
               next_r.index = r.index + 4'h1;
               if (r.index + 4'h1 == r.length) begin
                  next_r.phase = ST_CHECKSUM;
               end
            end
         end
         ST_CHECKSUM: begin
            if (push) begin
               next_r.phase = ST_IDLE;
            end
         end
         default: begin
            next_r.phase = ST_IDLE;
         end
      endcase
      // Two-entry buffer: the receiver may stall without losing a byte.
      case ({push, pop})
         2'b10: begin
            next_r.buf_data[r.count[0]] = push_byte;
            next_r.count = r.count + 2'h1;
         end
         2'b01: begin
            next_r.buf_data[0] = r.buf_data[1];
            next_r.count = r.count - 2'h1;
         end
         2'b11: begin
            if (r.count == 2'h1) begin
               next_r.buf_data[0] = push_byte;
            end else begin
               next_r.buf_data[0] = r.buf_data[1];
               next_r.buf_data[1] = push_byte;
            end
         end
         default: begin
            next_r.count = r.count;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   AST_ACK_FIRST: assert property (@(posedge clk_sys) disable iff (srst)
      (req_valid && req_ready && r.count == 2'h0) |-> ##2 (tx_valid && tx_data == ACK_BYTE))
      else $error("Acknowledge not first.");
   AST_HEADER_AFTER_ACK: assert property (@(posedge clk_sys) disable iff (srst)
      (push && push_byte == ACK_BYTE && r.phase == ST_ACK) |=>
      (r.phase == ST_HEADER)) else $error("Header does not follow ack.");
   AST_CHECKSUM_RANGE: assert property (@(posedge clk_sys) disable iff (srst)
      (r.phase == ST_CHECKSUM && push) |-> push_byte[7:4] == 4'h8)
      else $error("Checksum out of range.");
   AST_LATCH_FORMAT: assert property (@(posedge clk_sys) disable iff (srst)
      (req_ready && req_valid && req_kind == REQ_LATCH) |=>
      (r.data[0] == CHAR_LATCH && r.data[2] == CHAR_A && r.data[1][7:4] == 4'h3
      && r.data[3][7:3] == 5'h06)) else $error("Latch reply malformed.");
   AST_ERR_CLEARED: assert property (@(posedge clk_sys) disable iff (srst)
      (req_ready && req_valid && req_kind == REQ_LATCH && !bad_message) |=>
      !comm_error) else $error("Comm error not cleared after report.");
   AST_ERR_STICKY: assert property (@(posedge clk_sys) disable iff (srst)
      bad_message |=> comm_error) else $error("Comm error lost.");
   AST_PRESET_ACTIVE: assert property (@(posedge clk_sys) disable iff (srst)
      (req_ready && req_valid && req_kind == REQ_PRESET && goto_active) |=>
      r.data[1] == CHAR_A) else $error("Active status not reported.");
   AST_PAN_NIBBLE: assert property (@(posedge clk_sys) disable iff (srst)
      (req_ready && req_valid && req_kind == REQ_PAN_TILT) |=>
      r.data[1] == (NIBBLE_BASE | {4'h0, $past(azimuth_position[11:8])}))
      else $error("Azimuth nibble wrong.");
   AST_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (srst)
      r.count <= 2'h2) else $error("Buffer overflow.");
   COV_LATCH: cover property (@(posedge clk_sys) disable iff (srst)
      req_valid && req_ready && req_kind == REQ_LATCH);
   COV_STALL_FULL: cover property (@(posedge clk_sys) disable iff (srst)
      r.count == 2'h2 && !tx_ready);
   COV_PRESET_DONE: cover property (@(posedge clk_sys) disable iff (srst)
      r.phase == ST_CHECKSUM && push && r.kind == REQ_PRESET);
endmodule

// file: verification/ptz_host_model.sv
// Host-side byte sink for the response builder: stalls on demand and logs every byte taken.
`timescale 1ns/1ns
module ptz_host_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] rx_q[$];
   int stamp_q[$];
   int cyc = 0;
   // A slow host takes one cycle in three, so the two-entry buffer fills and must hold its bytes.
   assign tx_ready = !srst && (!slow || (cyc % 3 == 0));
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (tx_valid === 1'b1 && tx_ready) begin
         rx_q.push_back(tx_data);
         stamp_q.push_back(cyc);
      end
   end
endmodule

// file: verification/test_ptz_camera_response_builder.sv
// Self-checking bench: requests every reply kind and compares the framed byte stream.
`timescale 1ns/1ns
module test_ptz_camera_response_builder;
   import ptz_resp_pkg::*;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   request_type req_kind = REQ_PAN_TILT;
   logic [7:0] remote_address = 8'hdf;
   logic [11:0] azimuth_position = 12'habc;
   logic [11:0] elevation_position = 12'h123;
   logic [11:0] zoom_position = 12'h0f0;
   logic [11:0] focus_position = 12'hfff;
   logic iris_manual = 1'b1;
   logic camera_power_on = 1'b0;
   logic lens_speed_fast = 1'b1;
   logic [2:0] aux_output_on = 3'h5;
   logic bad_message = 1'b0;
   logic goto_active = 1'b0;
   logic goto_failed = 1'b0;
   logic at_preset = 1'b0;
   logic [3:0] preset_number = 4'h0;
   logic slow = 1'b0;
   logic ce_exp = 1'b0;
   logic req_ready, tx_valid, tx_ready, tx_busy, comm_error;
   logic [7:0] tx_data;
   int err_total = 0;
   int total_checks = 0;
   logic [3:0] preset_tab[6] = '{4'h0, 4'h9, 4'ha, 4'h3, 4'h5, 4'h5};
   logic [2:0] mode_tab[6] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h7, 3'h3};

   always #5 clk_sys = ~clk_sys;

   ptz_camera_response_builder #(.POS_WIDTH(12)) uut (.clk_sys(clk_sys), .srst(srst),
      .req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready),
      .remote_address(remote_address), .azimuth_position(azimuth_position),
      .elevation_position(elevation_position), .zoom_position(zoom_position),
      .focus_position(focus_position), .iris_manual(iris_manual),
      .camera_power_on(camera_power_on), .lens_speed_fast(lens_speed_fast),
      .aux_output_on(aux_output_on), .bad_message(bad_message), .goto_active(goto_active),
      .goto_failed(goto_failed), .at_preset(at_preset), .preset_number(preset_number),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_busy(tx_busy),
      .comm_error(comm_error));

   ptz_host_model h (.clk_sys(clk_sys), .srst(srst), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready));

   task automatic final_report();
      if (err_total == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask

   function automatic void put_pos(ref logic [7:0] q[$], input logic [11:0] v);
      for (int i = 2; i >= 0; i--) begin
         q.push_back(NIBBLE_BASE + {4'h0, v[i*4+:4]});
      end
   endfunction

   function automatic logic [7:0] preset_char();
      if (goto_active) return CHAR_A;
      if (goto_failed) return CHAR_ERROR;
      if (at_preset && preset_number <= 4'h9) return CHAR_ZERO + {4'h0, preset_number};
      return CHAR_IDLE;
   endfunction

   // Expected bytes are fixed before the take; disturb alters inputs afterwards and pokes
   // a request while busy, which must be ignored.
   task automatic run(input request_type kind, input logic slow_mode, input bit disturb);
      logic [7:0] d[$];
      logic [7:0] x;
      int n;
      // Inputs that the caller changed at the last edge have landed only after this one.
      @(posedge clk_sys);
      d = {ACK_BYTE, HEADER_BYTE, remote_address};
      case (kind)
         REQ_PAN_TILT: begin
            d.push_back(CHAR_PAN);
            put_pos(d, azimuth_position);
            put_pos(d, elevation_position);
         end
         REQ_ZOOM_FOCUS: begin
            d.push_back(CHAR_ZOOM);
            put_pos(d, zoom_position);
            put_pos(d, focus_position);
         end
         REQ_LATCH: d = {d, CHAR_LATCH, STATUS_BASE | {4'h0, ce_exp, lens_speed_fast,
            camera_power_on, iris_manual}, CHAR_A, STATUS_BASE | {5'h00, aux_output_on}};
         default: d = {d, CHAR_PRESET, preset_char()};
      endcase
      x = 8'h00;
      for (n = 2; n < d.size(); n++) x ^= d[n];
      d.push_back(CHECKSUM_BASE + {4'h0, x[3:0]});
      h.rx_q.delete();
      h.stamp_q.delete();
      slow <= slow_mode;
      req_valid <= 1'b1;
      req_kind <= kind;
      @(posedge clk_sys);
      req_valid <= disturb;
      req_kind <= REQ_LATCH;
      if (disturb) azimuth_position <= ~azimuth_position;
      if (kind == REQ_LATCH) ce_exp = 1'b0;
      #1;
      check_bit(req_ready, 1'b0);
      check_bit(tx_busy, 1'b1);
      @(posedge clk_sys);
      req_valid <= 1'b0;
      for (n = 0; n < 300 && h.rx_q.size() < d.size(); n++) @(posedge clk_sys);
      if (n == 300) begin
         err_total++;
         final_report();
      end
      repeat (6) @(posedge clk_sys);
      #1;
      check_byte(8'(h.rx_q.size()), 8'(d.size()));
      for (n = 0; n < d.size() && n < h.rx_q.size(); n++) check_byte(h.rx_q[n], d[n]);
      if (!slow_mode) check_byte(8'(h.stamp_q[$] - h.stamp_q[0]), 8'(d.size() - 1));
      check_bit(req_ready, 1'b1);
      check_bit(tx_busy, 1'b0);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      #1;
      check_bit(req_ready, 1'b1);
      check_bit(tx_valid, 1'b0);
      check_bit(comm_error, 1'b0);
      run(REQ_PAN_TILT, 1'b0, 1'b1);
      run(REQ_ZOOM_FOCUS, 1'b1, 1'b0);
      @(posedge clk_sys);
      bad_message <= 1'b1;
      @(posedge clk_sys);
      bad_message <= 1'b0;
      ce_exp = 1'b1;
      #1;
      check_bit(comm_error, 1'b1);
      run(REQ_LATCH, 1'b0, 1'b0);
      check_bit(comm_error, 1'b0);
      @(posedge clk_sys);
      {iris_manual, camera_power_on, lens_speed_fast, aux_output_on} <= 6'h12;
      run(REQ_LATCH, 1'b1, 1'b0);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         preset_number <= preset_tab[i];
         {goto_active, goto_failed, at_preset} <= mode_tab[i];
         run(REQ_PRESET, i[0], 1'b0);
      end
      final_report();
   end
endmodule
